/* File: hdl/relay_output_matrix.sv */
// Relay output matrix: routing, latching, forcing and slot remapping of coils
`timescale 1ns/1ps
`include "rom_map.svh"

module relay_output_matrix
  import rom_pkg::*;
#(
  parameter int NPROT = `ROM_NUM_SRC,
  parameter int NLOG  = `ROM_NUM_LOGIC,
  parameter int NTRIP = `ROM_NUM_TRIP
) (
  input  wire logic                              ref_clk_in,
  input  wire logic                              rst_n_in,
  input  wire logic [NPROT-1:0]                  prot_src_in,
  input  wire logic [NLOG-1:0]                   logic_src_in,
  input  wire logic [(NTRIP+2)*2*(NPROT+NLOG)-1:0] route_cfg_in,
  input  wire logic [NTRIP+1:0]                  out_latch_mode_in,
  input  wire logic [NTRIP+1:0]                  contact_nc_in,
  input  wire logic                              release_latches_in,
  input  wire logic                              force_flag_in,
  input  wire logic                              force_wr_in,
  input  wire logic [NTRIP+1:0]                  force_val_in,
  input  wire logic [`ROM_NUM_SLOTS*`ROM_SLOT_OUTS*4-1:0] slot_map_in,
  output rom_coils_t                             coil_out,
  output rom_coils_t                             status_out,
  output logic [NTRIP+1:0]                       contact_closed_out
);
  localparam int NSRC = NPROT + NLOG;
  localparam int NOUT = NTRIP + 2;
  localparam int NMAP = `ROM_NUM_SLOTS * `ROM_SLOT_OUTS;

  logic [NSRC-1:0] src_all;
  logic [NOUT-1:0] cell_coil;
  logic [NOUT-1:0] coil_mapped;
  logic [NOUT-1:0] coil_r;
  logic [NOUT-1:0] coil_nxt;
  logic            force_on_r;
  logic            force_on_nxt;

  // Logic outputs join the source vector directly
  assign src_all = {logic_src_in, prot_src_in};

  always_comb begin
    force_on_nxt = force_flag_in;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      force_on_r <= 1'b0;
    end else begin
      force_on_r <= force_on_nxt;
    end
  end

  genvar o;
  generate
    for (o = 0; o < NOUT; o++) begin : g_out
      rom_out_cell #(
        .NSRC (NSRC)
      ) u_cell (
        .ref_clk_in        (ref_clk_in),
        .rst_n_in          (rst_n_in),
        .src_in            (src_all),
        .route_in          (route_cfg_in[o*2*NSRC +: 2*NSRC]),
        .out_latch_mode_in (out_latch_mode_in[o]),
        .release_in        (release_latches_in),
        .force_on_in       (force_on_r),
        .force_wr_in       (force_wr_in),
        .force_val_in      (force_val_in[o]),
        .coil_out          (cell_coil[o])
      );
    end
  endgenerate

  // Slot outputs take the cell at their 4-bit map entry plus ROM_NUM_FIXED
  always_comb begin
    coil_mapped = cell_coil;
    for (int m = 0; m < NMAP; m++) begin
      if (`ROM_NUM_FIXED + m < NTRIP) begin
        coil_mapped[`ROM_NUM_FIXED + m] =
          cell_coil[`ROM_NUM_FIXED + int'(slot_map_in[m*4 +: 4])];
      end
    end
    coil_nxt = coil_mapped;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      coil_r <= '0;
    end else begin
      coil_r <= coil_nxt;
    end
  end

  always_comb begin
    coil_out.trip_output           = coil_r[NTRIP-1:0];
    coil_out.alarm_signal_output   = coil_r[NTRIP];
    coil_out.service_status_output = coil_r[NTRIP+1];
    status_out = coil_out;
    contact_closed_out = coil_r ^ contact_nc_in;
  end

  AST_STATUS_IS_COIL: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    status_out == coil_out)
    else $error("status differs from coil");
  AST_REST_POSITION: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !coil_r[0] |-> (contact_closed_out[0] == contact_nc_in[0]))
    else $error("de-energized contact not at rest");
  AST_FIXED_NUMBERING: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    coil_r[0] == $past(cell_coil[0]))
    else $error("supply card output remapped");
  AST_FORCE_LAG: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    force_flag_in |=> force_on_r)
    else $error("force flag not taken");
endmodule

/* File: hdl/rom_map.svh */
// Constants for the relay output matrix
`ifndef ROM_MAP_SVH
`define ROM_MAP_SVH
`define ROM_NUM_SRC      16
`define ROM_NUM_LOGIC    8
`define ROM_NUM_TRIP     16
`define ROM_NUM_FIXED    4
`define ROM_NUM_SLOTS    4
`define ROM_SLOT_OUTS    4
`define ROM_FIRST_SLOT   2
`define ROM_ROUTE_NONE   2'h0
`define ROM_ROUTE_PLAIN  2'h1
`define ROM_ROUTE_LATCH  2'h2
`endif

/* File: hdl/rom_pkg.sv */
// Types for the relay output matrix
package rom_pkg;
  typedef enum logic [1:0] {
    ROM_UNROUTED,
    ROM_ROUTED,
    ROM_ROUTED_LATCH,
    ROM_RESERVED
  } rom_route_t;

  typedef struct packed {
    logic [15:0] trip_output;
    logic        alarm_signal_output;
    logic        service_status_output;
  } rom_coils_t;
endpackage

/* File: hdl/rom_out_cell.sv */
// One output column: combines routed sources, holds latch, applies force
`timescale 1ns/1ps
module rom_out_cell
  import rom_pkg::*;
#(
  parameter int NSRC = 24
) (
  input  wire logic                ref_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic [NSRC-1:0]     src_in,
  input  wire logic [2*NSRC-1:0]   route_in,
  input  wire logic                out_latch_mode_in,
  input  wire logic                release_in,
  input  wire logic                force_on_in,
  input  wire logic                force_wr_in,
  input  wire logic                force_val_in,
  output logic                     coil_out
);
  logic plain_hit;
  logic latch_hit;
  logic latch_r;
  logic latch_nxt;
  logic force_r;
  logic force_nxt;
  logic coil_r;
  logic coil_nxt;

  always_comb begin
    plain_hit = 1'b0;
    latch_hit = 1'b0;
    for (int s = 0; s < NSRC; s++) begin
      if (rom_route_t'(route_in[2*s +: 2]) == ROM_ROUTED) begin
        plain_hit = plain_hit | src_in[s];
      end
      if (rom_route_t'(route_in[2*s +: 2]) == ROM_ROUTED_LATCH) begin
        latch_hit = latch_hit | src_in[s];
      end
    end
  end

  always_comb begin
    // Set wins over release so an active latched source is never lost
    latch_nxt = latch_r;
    if (release_in) begin
      latch_nxt = 1'b0;
    end
    if (latch_hit || (out_latch_mode_in && plain_hit)) begin
      latch_nxt = 1'b1;
    end
    force_nxt = force_r;
    if (force_on_in && force_wr_in) begin
      force_nxt = force_val_in;
    end
    if (force_on_in) begin
      coil_nxt = force_r;
    end else begin
      coil_nxt = plain_hit | latch_hit | latch_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_r <= 1'b0;
      force_r <= 1'b0;
      coil_r  <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      force_r <= force_nxt;
      coil_r  <= coil_nxt;
    end
  end

  assign coil_out = coil_r;

  AST_LATCH_HOLDS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (latch_r && !release_in && !force_on_in) |=> coil_r)
    else $error("latched coil dropped without release");
  AST_FORCE_BLOCKED: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!force_on_in) |=> (force_r == $past(force_r)))
    else $error("force value changed while force off");
endmodule

/* File: bench/rom_coil_model.sv */
// Relay coil and contact model for the output matrix bench
`timescale 1ns/1ps
module rom_coil_model
  import rom_pkg::*;
(
  input  wire rom_coils_t  coil_in,
  input  wire logic [17:0] contact_nc_in,
  output logic [17:0]      contact_closed_out
);
  logic [17:0] energized;
  assign energized = {coil_in.service_status_output, coil_in.alarm_signal_output,
                      coil_in.trip_output};
  // A resting coil leaves each contact at its normal position
  assign contact_closed_out = energized ^ contact_nc_in;
endmodule

/* File: bench/relay_output_matrix_tb_top.sv */
// Testbench for the relay output matrix
`timescale 1ns/1ps
module relay_output_matrix_tb_top;
  import rom_pkg::*;
  logic         ref_clk_in, rst_n_in, rel, ffl, fwr;
  logic [15:0]  prot;
  logic [7:0]   lsrc;
  logic [863:0] route;
  logic [17:0]  lmode, nc, fval, closed, mclosed;
  logic [63:0]  smap;
  rom_coils_t   coil, stat;
  int           bad_count, cmp_count;
  relay_output_matrix u_relay_output_matrix (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .prot_src_in(prot), .logic_src_in(lsrc), .route_cfg_in(route), .out_latch_mode_in(lmode),
    .contact_nc_in(nc), .release_latches_in(rel), .force_flag_in(ffl), .force_wr_in(fwr),
    .force_val_in(fval), .slot_map_in(smap), .coil_out(coil), .status_out(stat),
    .contact_closed_out(closed));
  rom_coil_model u_rom_coil_model (.coil_in(coil), .contact_nc_in(nc),
    .contact_closed_out(mclosed));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rt(input int o, input int s, input logic [1:0] v);
    route[o*48+2*s +: 2] = v;
  endtask
  task automatic relpulse();
    rel = 1'b1;
    cyc(1);
    rel = 1'b0;
    cyc(3);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    rst_n_in = 1'b0;
    {rel, ffl, fwr, prot, lsrc, route, lmode, fval} = '0;
    nc = 18'h00003;
    for (int m = 0; m < 16; m++) smap[m*4 +: 4] = m[3:0];
    cyc(5);
    chk("coil", coil, 18'h00000);
    chk("contact", closed, 18'h00003);
    rst_n_in = 1'b1;
    rt(0, 3, 2'h1);
    prot[3] = 1'b1;
    cyc(3);
    chk("coil", coil, 18'h00004);
    chk("contact", closed, mclosed);
    prot[3] = 1'b0;
    cyc(3);
    chk("coil", coil, 18'h00000);
    rt(16, 21, 2'h2);
    lsrc[5] = 1'b1;
    cyc(3);
    chk("coil", coil, 18'h00002);
    lsrc[5] = 1'b0;
    cyc(3);
    chk("coil", coil, 18'h00002);
    relpulse();
    chk("coil", coil, 18'h00000);
    rt(17, 0, 2'h1);
    lmode[17] = 1'b1;
    prot[0] = 1'b1;
    cyc(3);
    prot[0] = 1'b0;
    cyc(3);
    chk("coil", coil, 18'h00001);
    relpulse();
    chk("coil", coil, 18'h00000);
    fval = 18'h20020;
    fwr = 1'b1;
    cyc(1);
    fwr = 1'b0;
    cyc(4);
    chk("coil", coil, 18'h00000);
    ffl = 1'b1;
    cyc(2);
    fwr = 1'b1;
    cyc(1);
    fwr = 1'b0;
    cyc(4);
    chk("coil", coil, 18'h00081);
    chk("status", stat, 18'h00081);
    ffl = 1'b0;
    cyc(4);
    chk("coil", coil, 18'h00000);
    smap[3:0] = 4'h1;
    rt(5, 1, 2'h1);
    prot[1] = 1'b1;
    cyc(3);
    chk("coil", coil, 18'h000c0);
    close_out();
  end
endmodule
